// File: rtl/spg_cfg.svh
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH

// register offsets (index), byte address = 4 * index
`define SPG_IDX_DIR 4'hd
`define SPG_IDX_LVL 4'he
`define SPG_ADR_DIR 6'h34
`define SPG_ADR_LVL 6'h38
// reset values
`define SPG_RST_DIR 8'h00
`define SPG_RST_LVL 8'h00
// direction encoding
`define SPG_DIR_OUT 1'b0
`define SPG_DIR_IN 1'b1
// pin mapping
`define SPG_BIT_POS_REF 0
`define SPG_BIT_NEG_REF 1

`endif

// File: rtl/spg_pkg.sv
package spg_pkg;
  typedef enum logic [1:0] {
    SPG_BUS_IDLE = 2'b00,
    SPG_BUS_ACK = 2'b01
  } spg_bus_t;
endpackage

// File: rtl/spg_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "spg_cfg.svh"

// Function
// [R01] direction 0 output, 1 input; reset outputs
// [R02] bits 7..2 analog inputs, 1 neg, 0 pos ref
// [R03] output pin: read stored value, drive it
// [R04] input pin: write stores only, no drive
// [R05] data 0 low, 1 high; reset low
// [R06] level register at 0Eh, reset 00h
// [R07] four-pin variant: upper bits read zero
// [R08] direction register at 0Dh, reset 00h
// [R09] enable bit connects function to pin
// [R10] enabled input reads synchronized pin level
module spg_gpio_port
  import spg_pkg::*;
#(
  parameter int PINS = 8
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [5:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // per-pin function enable
  input wire logic [7:0] PIN_FUNCTION_ENABLE_BIT_I,
  // shared pins: bit 0 positive ref, bit 1 negative ref, 7..2 analog inputs
  input wire logic [7:0] PIN_I,
  output logic [7:0] PIN_O,
  output logic [7:0] PIN_OE_O
);

  // ----------------------------------------
  // implemented bit mask
  // ----------------------------------------
  // [R07] unimplemented bits held zero
  localparam logic [7:0] IMPL = (PINS >= 8) ? 8'hff : 8'h0f;

  spg_bus_t bus_state;
  logic [7:0] port_pin_direction;
  logic [7:0] port_pin_level;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] next_read;
  logic [7:0] level_view;
  logic hit_dir;
  logic hit_lvl;
  logic take;
  logic wr_dir;
  logic wr_lvl;
  logic rd_any;

  // ----------------------------------------
  // address decode and access strobes
  // ----------------------------------------
  assign hit_dir = (WB_ADR_I == `SPG_ADR_DIR);
  assign hit_lvl = (WB_ADR_I == `SPG_ADR_LVL);
  assign take = WB_CYC_I && WB_STB_I && (bus_state == SPG_BUS_IDLE);
  // only byte lane 0 carries register bits
  assign wr_dir = take && WB_WE_I && hit_dir && WB_SEL_I[0];
  assign wr_lvl = take && WB_WE_I && hit_lvl && WB_SEL_I[0];
  assign rd_any = take && !WB_WE_I;

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      bus_state <= SPG_BUS_IDLE;
      WB_ACK_O <= 1'b0;
    end else begin
      case (bus_state)
        SPG_BUS_IDLE: begin
          if (take) begin
            bus_state <= SPG_BUS_ACK;
            WB_ACK_O <= 1'b1;
          end
        end
        SPG_BUS_ACK: begin
          bus_state <= SPG_BUS_IDLE;
          WB_ACK_O <= 1'b0;
        end
        default: begin
          bus_state <= SPG_BUS_IDLE;
          WB_ACK_O <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= PIN_I;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // [R08] direction register, reset all outputs
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      port_pin_direction <= `SPG_RST_DIR;
    end else if (wr_dir) begin
      port_pin_direction <= WB_DAT_I[7:0] & IMPL;
    end
  end

  // [R06] level register, written regardless of direction
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      port_pin_level <= `SPG_RST_LVL;
    end else if (wr_lvl) begin
      port_pin_level <= WB_DAT_I[7:0] & IMPL;
    end
  end

  // ----------------------------------------
  // level read view, one per bit
  // ----------------------------------------
  for (genvar b = 0; b < 8; b++) begin : g_view
    always_comb begin
      if (!IMPL[b]) begin
        // [R07] unimplemented bit reads zero
        level_view[b] = 1'b0;
      end else if (port_pin_direction[b] == `SPG_DIR_OUT) begin
        // [R03] output reads stored bit
        level_view[b] = port_pin_level[b];
      end else if (PIN_FUNCTION_ENABLE_BIT_I[b]) begin
        // [R10] enabled input reads pin
        level_view[b] = pin_sync[b];
      end else begin
        // disconnected input keeps stored bit
        level_view[b] = port_pin_level[b];
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    next_read = 8'h00;
    if (hit_dir) begin
      next_read = port_pin_direction;
    end else if (hit_lvl) begin
      next_read = level_view;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (rd_any) begin
      WB_DAT_O <= {24'h00_0000, next_read};
    end else begin
      WB_DAT_O <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // pin drivers, one per pin
  // ----------------------------------------
  // [R02] bit index equals pin position
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
        PIN_O[i] <= 1'b0;
        PIN_OE_O[i] <= 1'b0;
      end else begin
        // [R05] stored level drives pin
        PIN_O[i] <= port_pin_level[i] & IMPL[i];
        // [R01] [R04] [R09] drive only enabled outputs
        PIN_OE_O[i] <= IMPL[i] && PIN_FUNCTION_ENABLE_BIT_I[i] && (port_pin_direction[i] == `SPG_DIR_OUT);
      end
    end
  end

endmodule
`default_nettype wire

// File: test/spg_gpio_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module spg_chk (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [7:0] PIN_FUNCTION_ENABLE_BIT_I,
  input wire logic [7:0] PIN_OE_O,
  input wire logic [7:0] PIN_O,
  input wire logic [31:0] WB_DAT_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  a_ack_due: assert property (WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  a_oe_enable: assert property ((PIN_OE_O & ~$past(PIN_FUNCTION_ENABLE_BIT_I)) == 8'h0)
    else $error("drive off pin");
  a_reset_idle: assert property (disable iff (1'b0) SRST_I |=> PIN_OE_O == 8'h0)
    else $error("reset drive");
  a_pin_low: assert property (disable iff (1'b0) SRST_I |=> PIN_O == 8'h0)
    else $error("reset level");
  a_data_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("data outside ack");
  a_data_upper: assert property (WB_DAT_O[31:8] == 24'h0)
    else $error("upper data set");
endmodule
bind spg_gpio_port spg_chk spg_chk_i (.MCLK_I, .SRST_I, .WB_STB_I, .WB_ACK_O, .PIN_FUNCTION_ENABLE_BIT_I, .PIN_OE_O,
  .PIN_O, .WB_DAT_O);
`default_nettype wire

// File: test/spg_pins.sv
`timescale 1ns/1ps
`default_nettype none
module spg_pins (
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  assign pin_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule
`default_nettype wire

// File: test/test_spg_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_spg_gpio_port;
  logic clk = 0, rst = 1, cyc = 0, we = 0;
  logic [5:0] adr = 0;
  logic [7:0] wd = 0, en = 8'hff, ext = 0;
  logic [31:0] q, q4;
  wire [31:0] rd, rd4;
  wire ack, ack4;
  wire [7:0] po, oe, pin, po4, oe4;
  int bad_count = 0, total_checks = 0;
  spg_gpio_port spg_gpio_port_i (.MCLK_I(clk), .SRST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I({24'h0, wd}), .WB_DAT_O(rd),
    .WB_ACK_O(ack), .PIN_FUNCTION_ENABLE_BIT_I(en), .PIN_I(pin), .PIN_O(po), .PIN_OE_O(oe));
  spg_gpio_port #(.PINS(4)) spg_gpio_port_s_i (.MCLK_I(clk), .SRST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I({24'h0, wd & 8'h0f}), .WB_DAT_O(rd4),
    .WB_ACK_O(ack4), .PIN_FUNCTION_ENABLE_BIT_I(en), .PIN_I(pin), .PIN_O(po4), .PIN_OE_O(oe4));
  spg_pins spg_pins_i (.drv_i(po), .oe_i(oe), .ext_i(ext), .pin_o(pin));
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    q4 = rd4;
    cyc <= 0;
    @(posedge clk);
  endtask
  task summarize;
    $display("%0d checks %0d bad", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (500) @(posedge clk);
    bad_count++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    bus(0, 6'h34, 0);
    chk("dir", q, 0);
    bus(0, 6'h38, 0);
    chk("lvl", q, 0);
    chk("oe", oe, 8'hff);
    chk("po", po, 0);
    bus(1, 6'h38, 8'ha5);
    ext <= 8'h5a;
    bus(0, 6'h38, 0);
    chk("out", q, 8'ha5);
    chk("small", q4, 8'h05);
    chk("po", po, 8'ha5);
    bus(1, 6'h34, 8'h0f);
    bus(1, 6'h38, 8'h3c);
    chk("oe", oe, 8'hf0);
    bus(0, 6'h38, 0);
    chk("in", q, 8'h3a);
    chk("small in", q4, 8'h0a);
    chk("small oe", oe4, 8'h00);
    bus(1, 6'h34, 0);
    chk("po", po, 8'h3c);
    en <= 8'h0;
    bus(0, 6'h00, 0);
    chk("bad", q, 0);
    chk("off", oe, 0);
    summarize;
  end
endmodule
`default_nettype wire
